//--- logic/pmw_status_regs.sv
// Indirect managed-device window and the three status-extension registers.
// Assumes the management engine, PCS and window target all run on clk_i.
`timescale 1ns/1ps
`default_nettype none

module pmw_status_regs
	import pmw_pkg::*;
#(
	parameter logic CAP_FDX = CAP_FDX_RST,
	parameter logic CAP_HDX = CAP_HDX_RST
) (
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	// Management register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	output logic                   reg_rvalid_o,
	// Fields of the neighbouring access-control register
	input  wire logic [1:0]        acc_function_i,
	input  wire logic [DEV_W-1:0]  mmd_device_select_i,
	// Clause 45 target behind the window
	output logic      [DEV_W-1:0]  managed_device_window_dev_o,
	output logic      [DATA_W-1:0] managed_device_window_addr_o,
	output logic      [DATA_W-1:0] managed_device_window_wdata_o,
	output logic                   managed_device_window_wr_o,
	output logic                   managed_device_window_rd_o,
	input  wire logic [DATA_W-1:0] managed_device_window_rdata_i,
	// Fast Ethernet receive path, live levels
	input  wire logic              fe_descr_locked_i,
	input  wire logic              fe_link_up_i,
	// Fast Ethernet event strobes
	input  wire logic              fe_lock_err_i,
	input  wire logic              fe_disconnect_i,
	input  wire logic              fe_rx_err_i,
	input  wire logic              fe_tx_err_i,
	input  wire logic              fe_stream_start_delimiter_err_i,
	input  wire logic              fe_stream_end_delimiter_err_i,
	// Gigabit receive path, live levels
	input  wire logic              ge_descr_locked_i,
	input  wire logic              ge_link_up_i,
	input  wire logic              ge_noncompliant_partner_i,
	input  wire logic              ge_mdi_crossover_err_i,
	// Gigabit event strobes
	input  wire logic              ge_lock_err_i,
	input  wire logic              ge_disconnect_i,
	input  wire logic              ge_rx_err_i,
	input  wire logic              ge_tx_err_i,
	input  wire logic              ge_stream_start_delimiter_err_i,
	input  wire logic              ge_stream_end_delimiter_err_i,
	input  wire logic              ge_carrier_ext_err_i
);

	////////////////////////////////////////////////////////////////////////
	// Request decode

	logic              hit_window;
	logic              hit_cap;
	logic              hit_fe;
	logic              hit_ge;
	logic              fn_is_addr;
	logic              win_addr_wr;
	logic              win_data_wr;
	logic              win_data_rd;
	logic              wr_incr;
	logic              rd_incr;

	assign hit_window  = (reg_addr_i == OFS_WINDOW);
	assign hit_cap     = (reg_addr_i == OFS_CAP);
	assign hit_fe      = (reg_addr_i == OFS_FE_STAT);
	assign hit_ge      = (reg_addr_i == OFS_GE_STAT);
	assign fn_is_addr  = (acc_function_i == PMW_FN_ADDRESS);
	assign win_addr_wr = reg_wr_i & hit_window & fn_is_addr;
	assign win_data_wr = reg_wr_i & hit_window & ~fn_is_addr;
	assign win_data_rd = reg_rd_i & hit_window & ~fn_is_addr;
	// Post-increment: both directions for one mode, writes only for the other
	assign wr_incr     = (acc_function_i == PMW_FN_DATA_INC)
	                   | (acc_function_i == PMW_FN_DATA_WINC);
	assign rd_incr     = (acc_function_i == PMW_FN_DATA_INC);

	////////////////////////////////////////////////////////////////////////
	// Window address and target strobes

	logic [DATA_W-1:0] addr_reg;
	logic [DATA_W-1:0] addr_next;
	logic [DEV_W-1:0]  dev_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic              c45_wr_reg;
	logic              c45_rd_reg;
	logic              wr_inc_reg;
	logic              rd_inc_reg;
	logic              bump;
	logic [DATA_W-1:0] addr_inc;

	// Increment after the strobe cycle, so the target sees a stable address
	assign bump      = (c45_wr_reg & wr_inc_reg) | (c45_rd_reg & rd_inc_reg);
	// Wraps at the top of the 16-bit space, no saturation
	assign addr_inc  = addr_reg + ADDR_STEP;
	assign addr_next = win_addr_wr ? reg_wdata_i :
	                   bump ? addr_inc : addr_reg;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_reg <= ADDR_RST;
		end else begin
			addr_reg <= addr_next;
		end
	end

	// Device select follows the access-control field
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			dev_reg <= '0;
		end else begin
			dev_reg <= mmd_device_select_i;
		end
	end

	// Target strobes follow the request one cycle later and last as long as it does
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			c45_wr_reg <= 1'b0;
			c45_rd_reg <= 1'b0;
		end else begin
			c45_wr_reg <= win_data_wr;
			c45_rd_reg <= win_data_rd;
		end
	end

	// Whether the strobe just issued is followed by an address step
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_inc_reg <= 1'b0;
			rd_inc_reg <= 1'b0;
		end else begin
			wr_inc_reg <= win_data_wr & wr_incr;
			rd_inc_reg <= win_data_rd & rd_incr;
		end
	end

	// Write data holds after the strobe, for a slow target
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wdata_reg <= WORD_ZERO;
		end else if (win_data_wr) begin
			wdata_reg <= reg_wdata_i;
		end
	end

	assign managed_device_window_dev_o   = dev_reg;
	assign managed_device_window_addr_o  = addr_reg;
	assign managed_device_window_wdata_o = wdata_reg;
	assign managed_device_window_wr_o    = c45_wr_reg;
	assign managed_device_window_rd_o    = c45_rd_reg;

	////////////////////////////////////////////////////////////////////////
	// Self-clearing event flags

	logic [NUM_FLAGS-1:0] flag_event;
	logic [NUM_FLAGS-1:0] flag_clear;
	logic [NUM_FLAGS-1:0] flag;
	logic                 rd_pend_reg;
	logic [ADDR_W-1:0]    rd_addr_reg;
	logic                 rd_fe;
	logic                 rd_ge;
	logic                 rd_at_window;
	logic                 rd_at_cap;
	logic                 rd_at_fe;
	logic                 rd_at_ge;

	assign flag_event[FE_FLAG_BASE+FL_LOCKE] = fe_lock_err_i;
	assign flag_event[FE_FLAG_BASE+FL_DISC]  = fe_disconnect_i;
	assign flag_event[FE_FLAG_BASE+FL_RXE]   = fe_rx_err_i;
	assign flag_event[FE_FLAG_BASE+FL_TXE]   = fe_tx_err_i;
	assign flag_event[FE_FLAG_BASE+FL_SSDE]  = fe_stream_start_delimiter_err_i;
	assign flag_event[FE_FLAG_BASE+FL_ESDE]  = fe_stream_end_delimiter_err_i;
	assign flag_event[GE_FLAG_BASE+FL_LOCKE] = ge_lock_err_i;
	assign flag_event[GE_FLAG_BASE+FL_DISC]  = ge_disconnect_i;
	assign flag_event[GE_FLAG_BASE+FL_RXE]   = ge_rx_err_i;
	assign flag_event[GE_FLAG_BASE+FL_TXE]   = ge_tx_err_i;
	assign flag_event[GE_FLAG_BASE+FL_SSDE]  = ge_stream_start_delimiter_err_i;
	assign flag_event[GE_FLAG_BASE+FL_ESDE]  = ge_stream_end_delimiter_err_i;
	assign flag_event[GE_FLAG_BASE+FL_CEXT]  = ge_carrier_ext_err_i;

	// Held address decoded once, for the read mux and the clears alike
	assign rd_at_window = (rd_addr_reg == OFS_WINDOW);
	assign rd_at_cap    = (rd_addr_reg == OFS_CAP);
	assign rd_at_fe     = (rd_addr_reg == OFS_FE_STAT);
	assign rd_at_ge     = (rd_addr_reg == OFS_GE_STAT);

	// Clear in the cycle the read word is captured
	assign rd_fe = rd_pend_reg & rd_at_fe;
	assign rd_ge = rd_pend_reg & rd_at_ge;
	assign flag_clear = {{GE_NUM_FLAGS{rd_ge}}, {FE_NUM_FLAGS{rd_fe}}};

	pmw_flag_bank #(
		.N       (NUM_FLAGS)
	) u_flags (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.event_i (flag_event),
		.clear_i (flag_clear),
		.flag_o  (flag)
	);

	////////////////////////////////////////////////////////////////////////
	// Read words

	logic [DATA_W-1:0] cap_word;
	logic [DATA_W-1:0] fe_word;
	logic [DATA_W-1:0] ge_word;
	logic [DATA_W-1:0] win_word;
	logic [DATA_W-1:0] rd_word;
	logic              rd_win_data_reg;
	logic [DATA_W-1:0] win_sel;
	logic [DATA_W-1:0] cap_sel;
	logic [DATA_W-1:0] fe_sel;
	logic [DATA_W-1:0] ge_sel;

	// Per-speed views of the flag bank
	logic [FE_NUM_FLAGS-1:0] fe_flag;
	logic [GE_NUM_FLAGS-1:0] ge_flag;

	assign fe_flag = flag[FE_FLAG_BASE +: FE_NUM_FLAGS];
	assign ge_flag = flag[GE_FLAG_BASE +: GE_NUM_FLAGS];

	always_comb begin
		cap_word = WORD_ZERO;
		cap_word[CAP_FDX_BIT] = CAP_FDX;
		cap_word[CAP_HDX_BIT] = CAP_HDX;
	end

	always_comb begin
		fe_word = WORD_ZERO;
		fe_word[ST_LOCK_BIT]  = fe_descr_locked_i;
		fe_word[ST_LOCKE_BIT] = fe_flag[FL_LOCKE];
		fe_word[ST_DISC_BIT]  = fe_flag[FL_DISC];
		fe_word[ST_LINK_BIT]  = fe_link_up_i;
		fe_word[ST_RXE_BIT]   = fe_flag[FL_RXE];
		fe_word[ST_TXE_BIT]   = fe_flag[FL_TXE];
		fe_word[ST_SSDE_BIT]  = fe_flag[FL_SSDE];
		fe_word[ST_ESDE_BIT]  = fe_flag[FL_ESDE];
	end

	// Bits 4:0 stay zero
	always_comb begin
		ge_word = WORD_ZERO;
		ge_word[ST_LOCK_BIT]  = ge_descr_locked_i;
		ge_word[ST_LOCKE_BIT] = ge_flag[FL_LOCKE];
		ge_word[ST_DISC_BIT]  = ge_flag[FL_DISC];
		ge_word[ST_LINK_BIT]  = ge_link_up_i;
		ge_word[ST_RXE_BIT]   = ge_flag[FL_RXE];
		ge_word[ST_TXE_BIT]   = ge_flag[FL_TXE];
		ge_word[ST_SSDE_BIT]  = ge_flag[FL_SSDE];
		ge_word[ST_ESDE_BIT]  = ge_flag[FL_ESDE];
		ge_word[ST_CEXT_BIT]  = ge_flag[FL_CEXT];
		ge_word[ST_NONC_BIT]  = ge_noncompliant_partner_i;
		ge_word[ST_XOVER_BIT] = ge_mdi_crossover_err_i;
	end

	// Target read data is valid in the read-strobe cycle
	assign win_word = rd_win_data_reg ? managed_device_window_rdata_i : addr_reg;

	// One-hot AND-OR select; unmapped addresses read as zero
	assign win_sel = {DATA_W{rd_at_window}} & win_word;
	assign cap_sel = {DATA_W{rd_at_cap}} & cap_word;
	assign fe_sel  = {DATA_W{rd_at_fe}} & fe_word;
	assign ge_sel  = {DATA_W{rd_at_ge}} & ge_word;
	assign rd_word = win_sel | cap_sel | fe_sel | ge_sel;

	////////////////////////////////////////////////////////////////////////
	// Two-stage read: strobe the target, then capture

	logic [DATA_W-1:0] rdata_reg;
	logic              rvalid_reg;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rd_pend_reg     <= 1'b0;
			rd_win_data_reg <= 1'b0;
		end else begin
			rd_pend_reg     <= reg_rd_i;
			rd_win_data_reg <= win_data_rd;
		end
	end

	// Address held past the request, for the capture and the clears
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rd_addr_reg <= '0;
		end else if (reg_rd_i) begin
			rd_addr_reg <= reg_addr_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= rd_pend_reg;
		end
	end

	// Read data holds until the next answer, so a slow master can sample late
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_reg <= WORD_ZERO;
		end else if (rd_pend_reg) begin
			rdata_reg <= rd_word;
		end
	end

	assign reg_rdata_o  = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

	// Unused decode terms kept for writes to read-only registers
	logic unused_ro_wr;
	assign unused_ro_wr = reg_wr_i & (hit_cap | hit_fe | hit_ge);

endmodule

`default_nettype wire

//--- logic/pmw_pkg.sv
// Constants for the managed-device window and link status registers.
// Assumes a 5-bit management register address and 16-bit register data.
//
// What this block does
// - Address mode write loads window target address
// - Data modes move data to addressed register
// - Capability bit 13 reads one, read-only
// - Capability bit 12 reads one, others reserved
// - Fast Ethernet live link at bit 12
// - Gigabit live link at bit 12
// - Fast Ethernet disconnect flag at bit 13
// - Gigabit disconnect flag at bit 13
// - Lock-error flag bit 14, live lock 15
// - Receive-error flag at bit 11
// - Transmit-error flag at bit 10
// - Bad start delimiter flag at bit 9
// - Bad end delimiter flag at bit 8
// - Gigabit carrier-extension error flag at bit 7
// - Gigabit non-compliant partner at bit 6
// - Gigabit crossover error bit 5, 4:0 reserved
// - Function field picks address or data modes
// - Device-select field picks the target device

`default_nettype none

package pmw_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int DEV_W  = 5;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_WINDOW   = 5'h0E;
	localparam logic [ADDR_W-1:0] OFS_CAP      = 5'h0F;
	localparam logic [ADDR_W-1:0] OFS_FE_STAT  = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_GE_STAT  = 5'h11;

	// Access-control function field encodings
	typedef enum logic [1:0] {
		PMW_FN_ADDRESS   = 2'b00,
		PMW_FN_DATA      = 2'b01,
		PMW_FN_DATA_INC  = 2'b10,
		PMW_FN_DATA_WINC = 2'b11
	} pmw_fn_type;

	// Bit positions in the capability register
	localparam int CAP_FDX_BIT = 13;
	localparam int CAP_HDX_BIT = 12;
	localparam logic CAP_FDX_RST = 1'b1;
	localparam logic CAP_HDX_RST = 1'b1;

	// Bit positions shared by both speed status registers
	localparam int ST_LOCK_BIT   = 15;
	localparam int ST_LOCKE_BIT  = 14;
	localparam int ST_DISC_BIT   = 13;
	localparam int ST_LINK_BIT   = 12;
	localparam int ST_RXE_BIT    = 11;
	localparam int ST_TXE_BIT    = 10;
	localparam int ST_SSDE_BIT   = 9;
	localparam int ST_ESDE_BIT   = 8;
	// Gigabit only
	localparam int ST_CEXT_BIT   = 7;
	localparam int ST_NONC_BIT   = 6;
	localparam int ST_XOVER_BIT  = 5;

	// Index of each self-clearing flag in the flag bank
	localparam int NUM_FLAGS    = 13;
	localparam int FE_FLAG_BASE = 0;
	localparam int FE_NUM_FLAGS = 6;
	localparam int GE_FLAG_BASE = 6;
	localparam int GE_NUM_FLAGS = 7;
	localparam int FL_LOCKE = 0;
	localparam int FL_DISC  = 1;
	localparam int FL_RXE   = 2;
	localparam int FL_TXE   = 3;
	localparam int FL_SSDE  = 4;
	localparam int FL_ESDE  = 5;
	localparam int FL_CEXT  = 6;

	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] ADDR_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] ADDR_STEP = 16'h0001;

endpackage

`default_nettype wire

//--- logic/pmw_flag_bank.sv
// Bank of self-clearing event flags, one flip-flop per flag.
// Assumes events and clears are single-cycle strobes on clk_i.
`timescale 1ns/1ps
`default_nettype none

module pmw_flag_bank #(
	parameter int N = 13
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [N-1:0] event_i,
	input  wire logic [N-1:0] clear_i,
	output logic      [N-1:0] flag_o
);

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_flag
			logic flag_reg;
			logic flag_next;
			// Event in the clearing cycle survives
			assign flag_next = event_i[g] | (flag_reg & ~clear_i[g]);
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					flag_reg <= 1'b0;
				end else begin
					flag_reg <= flag_next;
				end
			end
			assign flag_o[g] = flag_reg;
		end
	endgenerate

endmodule

`default_nettype wire

//--- tb/pmw_props.sv
// Concurrent checks on the window and status register ports.
// Assumes binding into pmw_status_regs with matching port names.
`timescale 1ns/1ps
`default_nettype none

module pmw_props
	import pmw_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              nrst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic              reg_wr_i,
	input wire logic              reg_rd_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic              reg_rvalid_o,
	input wire logic [1:0]        acc_function_i,
	input wire logic [DEV_W-1:0]  mmd_device_select_i,
	input wire logic [DEV_W-1:0]  managed_device_window_dev_o,
	input wire logic [DATA_W-1:0] managed_device_window_addr_o,
	input wire logic [DATA_W-1:0] managed_device_window_wdata_o,
	input wire logic              managed_device_window_wr_o,
	input wire logic              managed_device_window_rd_o,
	input wire logic [DATA_W-1:0] managed_device_window_rdata_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////
	wire logic [15:0] wa     = managed_device_window_addr_o;
	wire logic        win    = (reg_addr_i == OFS_WINDOW);
	wire logic        dmode  = (acc_function_i != PMW_FN_ADDRESS);
	wire logic        adr_wr = reg_wr_i && win && !dmode;
	wire logic        adr_rd = reg_rd_i && win && !dmode;
	wire logic        dat_wr = reg_wr_i && win && dmode;
	wire logic        dat_rd = reg_rd_i && win && dmode;
	////////////////////////////////////////////////////////////////
	a_read_lat: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
		else $error("read answer not two cycles later");
	a_valid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
		else $error("read answer without request");
	a_addr_load: assert property (
		adr_wr |=> wa == $past(reg_wdata_i)) else $error("window address not loaded");
	a_addr_readback: assert property (
		adr_rd |=> !managed_device_window_rd_o ##1 reg_rdata_o == wa)
		else $error("address read wrong");
	a_data_write: assert property (
		dat_wr |=> managed_device_window_wr_o && wa == $past(wa) &&
		managed_device_window_wdata_o == $past(reg_wdata_i)) else $error("target write wrong");
	a_data_read: assert property (
		dat_rd |=> managed_device_window_rd_o ##1
		reg_rdata_o == $past(managed_device_window_rdata_i)) else $error("target read wrong");
	a_wr_step: assert property (
		dat_wr |-> ##2 wa == $past(wa) + {15'h0000, $past(acc_function_i[1], 2)})
		else $error("write increment wrong");
	a_rd_step: assert property (
		dat_rd |-> ##2 wa == $past(wa) + {15'h0000, $past(acc_function_i, 2) == 2'h2})
		else $error("read increment wrong");
	a_dev_follow: assert property (
		1'b1 |=> managed_device_window_dev_o == $past(mmd_device_select_i))
		else $error("device select not passed");
	a_cap_value: assert property (
		reg_rd_i && reg_addr_i == OFS_CAP |-> ##2 reg_rdata_o == 16'h3000)
		else $error("capability word wrong");
	c_dat_wr: cover property (dat_wr ##2 1'b1);
	c_dat_rd: cover property (dat_rd ##2 reg_rvalid_o);
	c_cext: cover property (reg_rd_i && reg_addr_i == OFS_GE_STAT ##2 reg_rdata_o[ST_CEXT_BIT]);
endmodule

bind pmw_status_regs pmw_props u_props (.*);

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the window and status registers.
// Assumes pmw_status_regs with default capability parameters.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import pmw_pkg::*;
	logic              clk_i = 1'b0;
	logic              nrst_i = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i = 5'h00;
	logic              reg_wr_i = 1'b0;
	logic              reg_rd_i = 1'b0;
	logic [DATA_W-1:0] reg_wdata_i = 16'h0000;
	logic [1:0]        acc_function_i = 2'h0;
	logic [DEV_W-1:0]  mmd_device_select_i = 5'h00;
	logic [DATA_W-1:0] reg_rdata_o, managed_device_window_addr_o;
	logic [DATA_W-1:0] managed_device_window_wdata_o, managed_device_window_rdata_i;
	logic [DEV_W-1:0]  managed_device_window_dev_o;
	logic              reg_rvalid_o, managed_device_window_wr_o, managed_device_window_rd_o;
	logic              fe_descr_locked_i, fe_link_up_i, fe_lock_err_i, fe_disconnect_i;
	logic              fe_rx_err_i, fe_tx_err_i, fe_stream_start_delimiter_err_i;
	logic              fe_stream_end_delimiter_err_i, ge_descr_locked_i, ge_link_up_i;
	logic              ge_noncompliant_partner_i, ge_mdi_crossover_err_i, ge_lock_err_i;
	logic              ge_disconnect_i, ge_rx_err_i, ge_tx_err_i, ge_carrier_ext_err_i;
	logic              ge_stream_start_delimiter_err_i, ge_stream_end_delimiter_err_i;
	logic [5:0]        lv = 6'h00;
	logic [5:0]        fev = 6'h00;
	logic [6:0]        gev = 7'h00;
	logic [31:0]       seed = 32'h00000029;
	int                mismatches = 0;
	int                checked = 0;
	////////////////////////////////////////////////////////////////
	assign {ge_mdi_crossover_err_i, ge_noncompliant_partner_i, ge_link_up_i,
		ge_descr_locked_i, fe_link_up_i, fe_descr_locked_i} = lv;
	assign {fe_stream_end_delimiter_err_i, fe_stream_start_delimiter_err_i, fe_tx_err_i,
		fe_rx_err_i, fe_disconnect_i, fe_lock_err_i} = fev;
	assign {ge_carrier_ext_err_i, ge_stream_end_delimiter_err_i, ge_stream_start_delimiter_err_i,
		ge_tx_err_i, ge_rx_err_i, ge_disconnect_i, ge_lock_err_i} = gev;
	// Target answers with a pattern of its address, so a wrong address shows
	assign managed_device_window_rdata_i = managed_device_window_addr_o ^ 16'hA5C3;
	pmw_status_regs uut (.*);
	always #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] fe_word(logic [5:0] l, logic [5:0] f);
		return {l[0], f[0], f[1], l[1], f[2], f[3], f[4], f[5], 8'h00};
	endfunction
	function automatic logic [15:0] ge_word(logic [5:0] l, logic [6:0] f);
		return {l[2], f[0], f[1], l[3], f[2], f[3], f[4], f[5], f[6], l[4], l[5], 5'h00};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	// Bounded wait: a lost answer leaves stale data and fails the compare
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		int n;
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		for (n = 0; n < 4 && reg_rvalid_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		chk(reg_rdata_o, exp);
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		mismatches++;
		close_out();
	end
	initial begin
		logic [31:0] r;
		logic [15:0] a, ea;
		logic [5:0]  fa;
		logic [6:0]  ga;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(OFS_CAP, 16'h3000);
		wr(OFS_CAP, 16'hFFFF);
		rd(OFS_CAP, 16'h3000);
		wr(5'h05, 16'h1234);
		rd(5'h05, 16'h0000);
		rd(OFS_FE_STAT, 16'h0000);
		rd(OFS_GE_STAT, 16'h0000);
		for (int f = 0; f < 4; f++) begin
			r = rnd();
			a = r[15:0];
			@(posedge clk_i);
			acc_function_i <= 2'h0;
			mmd_device_select_i <= r[20:16];
			wr(OFS_WINDOW, a);
			rd(OFS_WINDOW, a);
			@(posedge clk_i);
			acc_function_i <= 2'(f);
			wr(OFS_WINDOW, r[31:16]);
			// Address mode reloads the address; data modes may step it
			ea = (f == 0) ? r[31:16] : a + {15'h0000, f >= 2};
			chk(managed_device_window_addr_o, ea);
			if (f != 0) begin
				chk(managed_device_window_wdata_o, r[31:16]);
			end
			chk({11'h000, managed_device_window_dev_o}, {11'h000, r[20:16]});
			rd(OFS_WINDOW, (f == 0) ? ea : ea ^ 16'hA5C3);
			if (f == 2) ea = ea + 16'h0001;
			chk(managed_device_window_addr_o, ea);
		end
		// Event held one cycle past the clearing read: the flag must read set again, then clear
		@(posedge clk_i);
		gev <= 7'h7F;
		rd(OFS_GE_STAT, ge_word(lv, 7'h7F));
		@(posedge clk_i);
		gev <= 7'h00;
		rd(OFS_GE_STAT, ge_word(lv, 7'h7F));
		rd(OFS_GE_STAT, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			fa = r[13:8] & {6{r[30]}};
			ga = r[22:16] & {7{r[30]}};
			@(posedge clk_i);
			lv <= r[5:0];
			fev <= fa;
			gev <= ga;
			@(posedge clk_i);
			fev <= 6'h00;
			gev <= 7'h00;
			rd(OFS_FE_STAT, fe_word(r[5:0], fa));
			rd(OFS_GE_STAT, ge_word(r[5:0], ga));
			rd(OFS_FE_STAT, fe_word(r[5:0], 6'h00));
		end
		close_out();
	end
endmodule

`default_nettype wire
